// ===== logic/jsd_move_decoder.sv
// Move command decoder: jog, step and station start from the remote command message
// How it works
// - Direction bit steers every commanded move
// - Jog request bit starts continuous travel
// - Unit select picks ratio or speed override
// - Jog continues while bit held, tracks override
// - Step moves selected distance then stops
// - Byte 4 selector picks one stored distance
// - Exactly four stored step distances exist
// - Step request bit starts a step move
// - Station spacing set by pitch register, station count bounds number
// - Station move targets that station's position
`timescale 1ns/1ps
module jsd_move_decoder
  import jsd_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Command message and axis feedback
  input wire jsd_cmd_t cmd_i,
  input wire logic [31:0] present_pos_i,
  input wire logic motion_done_i,
  // Motion order
  output jsd_move_t move_o,
  output logic busy_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_JOG, ST_STEP_LOAD, ST_MOVING} jsd_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus
  logic pend, next_pend, ack, next_ack, unit_sel, next_unit_sel, reject, next_reject, mem_we;
  logic [31:0] dat, next_dat, pitch, next_pitch, bus_dist, step_dist, wmask;
  logic [31:0] jog_speed, next_jog_speed, move_speed, next_move_speed;
  logic [15:0] stations, next_stations;
  logic [SEL_W-1:0] sel, next_sel;
  logic bus_wr;
  jsd_state_t state, next_state;
  jsd_move_t move, next_move;
  logic [7:0] prev_b2, next_prev_b2;
  assign bus_wr = pend && wb_we_i;
  assign wb_ack_o = ack;
  assign wb_dat_o = dat;
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      wmask[8*i +: 8] = {8{wb_sel_i[i]}};
  end

  jsd_dist_mem u_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(mem_we),
    .waddr_i(wb_adr_i[3:2]),
    .wdata_i((bus_dist & ~wmask) | (wb_dat_i & wmask)),
    .raddr_a_i(wb_adr_i[3:2]),
    .rdata_a_o(bus_dist),
    .raddr_b_i(next_sel),
    .rdata_b_o(step_dist)
  );

  // Request seen in first cycle, answered with ack in the second
  always_comb
  begin
    next_pend = wb_cyc_i && wb_stb_i && !pend && !ack;
    next_ack = pend;
    next_dat = '0;
    next_unit_sel = unit_sel;
    next_jog_speed = jog_speed;
    next_move_speed = move_speed;
    next_pitch = pitch;
    next_stations = stations;
    mem_we = 1'b0;
    if (wb_adr_i == OFS_CTRL)
    begin
      next_dat = {31'h0000_0000, unit_sel};
      if (bus_wr && wb_sel_i[0])
        next_unit_sel = wb_dat_i[0];
    end
    else if (wb_adr_i == OFS_JOG_SPEED)
    begin
      next_dat = jog_speed;
      if (bus_wr)
        next_jog_speed = (jog_speed & ~wmask) | (wb_dat_i & wmask);
    end
    else if (wb_adr_i == OFS_MOVE_SPEED)
    begin
      next_dat = move_speed;
      if (bus_wr)
        next_move_speed = (move_speed & ~wmask) | (wb_dat_i & wmask);
    end
    else if (wb_adr_i == OFS_PITCH)
    begin
      next_dat = pitch;
      if (bus_wr)
        next_pitch = (pitch & ~wmask) | (wb_dat_i & wmask);
    end
    else if (wb_adr_i == OFS_STATIONS)
    begin
      next_dat = {16'h0000, stations};
      if (bus_wr)
        next_stations = (stations & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
    end
    else if (wb_adr_i == OFS_STATUS)
      next_dat = {26'h000_0000, reject, move.dir, busy_o, state == ST_JOG, state};
    else if (wb_adr_i == OFS_TARGET)
      next_dat = move.target;
    else if (wb_adr_i >= OFS_DIST0 && wb_adr_i <= OFS_DIST3)
    begin
      next_dat = bus_dist;
      mem_we = bus_wr;
    end
    if (!pend)
      next_dat = '0;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pend <= 1'b0;
      ack <= 1'b0;
      dat <= '0;
      unit_sel <= 1'b0;
      jog_speed <= RST_JOG_SPEED;
      move_speed <= RST_MOVE_SPEED;
      pitch <= RST_PITCH;
      stations <= RST_STATIONS;
    end
    else
    begin
      pend <= next_pend;
      ack <= next_ack;
      dat <= next_dat;
      unit_sel <= next_unit_sel;
      jog_speed <= next_jog_speed;
      move_speed <= next_move_speed;
      pitch <= next_pitch;
      stations <= next_stations;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode and move sequencing
  logic servo_on, jog_req, step_rise, station_rise;
  logic [31:0] ovr, ovr_speed, station_pos;
  logic [39:0] ratio_prod;
  logic [15:0] station_no;

  assign servo_on = cmd_i.b0[SERVO_BIT];
  assign jog_req = cmd_i.b2[JOG_BIT] && servo_on;
  assign step_rise = cmd_i.b2[STEP_BIT] && !prev_b2[STEP_BIT] && servo_on;
  assign station_rise = cmd_i.b2[STATION_BIT] && !prev_b2[STATION_BIT] && servo_on;
  assign station_no = cmd_i.data[STATION_W-1:0];
  assign station_pos = 32'(station_no * pitch);
  assign busy_o = state != ST_IDLE;

  // Override as percentage of the jog speed, or as a speed itself
  always_comb
  begin
    ovr = unit_sel ? ((cmd_i.data > SPEED_MAX) ? SPEED_MAX : cmd_i.data)
                   : ((cmd_i.data > RATIO_MAX) ? RATIO_MAX : cmd_i.data);
    ratio_prod = 40'(jog_speed) * 40'(ovr[7:0]);
    ovr_speed = unit_sel ? ovr : 32'(ratio_prod / 40'(RATIO_FULL));
  end

  always_comb
  begin
    next_state = state;
    next_move = move;
    next_move.start = 1'b0;
    next_sel = sel;
    next_reject = reject;
    next_prev_b2 = cmd_i.b2;
    case (state)
      ST_IDLE:
      begin
        next_move.speed = '0;
        if (jog_req && !prev_b2[JOG_BIT])
        begin
          next_state = ST_JOG;
          next_move = '{start: 1'b1, kind: MK_JOG, dir: cmd_i.b3[DIR_BIT],
                        target: present_pos_i, speed: ovr_speed};
        end
        else if (step_rise)
        begin
          next_state = ST_STEP_LOAD;
          next_sel = cmd_i.data[SEL_W-1:0];
          next_move.dir = cmd_i.b3[DIR_BIT];
        end
        else if (station_rise)
        begin
          next_reject = station_no >= stations;
          if (station_no < stations)
          begin
            next_state = ST_MOVING;
            next_move = '{start: 1'b1, kind: MK_STATION, dir: cmd_i.b3[DIR_BIT],
                          target: station_pos, speed: move_speed};
          end
        end
      end
      ST_JOG:
      begin
        next_move.speed = ovr_speed;
        if (!jog_req)
        begin
          next_state = ST_IDLE;
          next_move.speed = '0;
        end
      end
      ST_STEP_LOAD:
      begin
        next_state = ST_MOVING;
        next_move.start = 1'b1;
        next_move.kind = MK_STEP;
        next_move.speed = move_speed;
        next_move.target = move.dir ? present_pos_i - step_dist
                                    : present_pos_i + step_dist;
      end
      default:
      begin
        if (motion_done_i)
        begin
          next_state = ST_IDLE;
          next_move.speed = '0;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= ST_IDLE;
      move <= '0;
      sel <= '0;
      reject <= 1'b0;
      prev_b2 <= '0;
    end
    else
    begin
      state <= next_state;
      move <= next_move;
      sel <= next_sel;
      reject <= next_reject;
      prev_b2 <= next_prev_b2;
    end
  end

  assign move_o = move;
  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_step_req;
    state == ST_IDLE && step_rise && !(jog_req && !prev_b2[JOG_BIT]);
  endsequence
  sequence s_step_issue;
    state == ST_STEP_LOAD ##1 (move.start && move.kind == MK_STEP && state == ST_MOVING);
  endsequence

  a_step_start: assert property (@(posedge clk_i) disable iff (rst_i)
    s_step_req |=> s_step_issue) else $error("step not issued");
  a_step_dir_target: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_STEP_LOAD |=> move.target == ($past(move.dir) ?
      $past(present_pos_i) - $past(step_dist) : $past(present_pos_i) + $past(step_dist)))
    else $error("step target wrong");
  a_step_select: assert property (@(posedge clk_i) disable iff (rst_i)
    s_step_req |=> sel == $past(cmd_i.data[SEL_W-1:0])) else $error("distance select wrong");
  a_jog_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_JOG && !servo_on |=> state == ST_IDLE && move.speed == '0)
    else $error("jog kept without servo");
  a_jog_track: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_JOG && jog_req |=> move.speed == $past(ovr_speed))
    else $error("jog speed not tracking");
  a_ratio_unit: assert property (@(posedge clk_i) disable iff (rst_i)
    !unit_sel && cmd_i.data == RATIO_FULL |-> ovr_speed == jog_speed)
    else $error("ratio override wrong");
  a_no_servo_start: assert property (@(posedge clk_i) disable iff (rst_i)
    !servo_on && state == ST_IDLE |=> !move.start) else $error("start without servo");
  a_station_go: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_IDLE && station_rise && !step_rise && !jog_req && station_no < stations
    |=> move.start && move.target == $past(station_pos) && move.dir == $past(cmd_i.b3[DIR_BIT]))
    else $error("station move wrong");
  a_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !pend && !ack |=> ##1 ack ##1 !ack)
    else $error("bus ack timing wrong");
endmodule

// ===== logic/jsd_pkg.sv
// Shared constants and types of the jog, step and station command decoder
package jsd_pkg;
  // Command message bit positions and field widths
  localparam int unsigned SERVO_BIT = 1;
  localparam int unsigned DIR_BIT = 1;
  localparam int unsigned JOG_BIT = 3;
  localparam int unsigned STEP_BIT = 4;
  localparam int unsigned STATION_BIT = 5;
  localparam int unsigned SEL_W = 2;
  localparam int unsigned STATION_W = 16;
  // Override limits and units
  localparam logic [31:0] RATIO_MAX = 32'h0000_00c8;
  localparam logic [31:0] RATIO_FULL = 32'h0000_0064;
  localparam logic [31:0] SPEED_MAX = 32'h0003_a980;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_JOG_SPEED = 8'h04;
  localparam logic [7:0] OFS_MOVE_SPEED = 8'h08;
  localparam logic [7:0] OFS_PITCH = 8'h0c;
  localparam logic [7:0] OFS_STATIONS = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_TARGET = 8'h18;
  localparam logic [7:0] OFS_DIST0 = 8'h20;
  localparam logic [7:0] OFS_DIST3 = 8'h2c;
  localparam int unsigned ADR_W = 8;
  // Reset values
  localparam logic [31:0] RST_JOG_SPEED = 32'h0000_5dc0;
  localparam logic [31:0] RST_MOVE_SPEED = 32'h0000_5dc0;
  localparam logic [31:0] RST_PITCH = 32'h0000_0001;
  localparam logic [15:0] RST_STATIONS = 16'h0001;
  localparam logic [31:0] RST_DIST [4] = '{32'h0000_0001, 32'h0000_000a,
                                           32'h0000_0064, 32'h0000_03e8};
  typedef enum logic [1:0] {MK_JOG, MK_STEP, MK_STATION} jsd_kind_t;
  // Eight byte command message, bytes 4..7 as one little-endian word
  typedef struct packed {
    logic [31:0] data;
    logic [7:0] b3;
    logic [7:0] b2;
    logic [7:0] b1;
    logic [7:0] b0;
  } jsd_cmd_t;
  // Order to the motion profile generator
  typedef struct packed {
    logic start;
    jsd_kind_t kind;
    logic dir;
    logic [31:0] target;
    logic [31:0] speed;
  } jsd_move_t;
endpackage

// ===== logic/jsd_dist_mem.sv
// Four stored step distances with one write port and two registered read ports
`timescale 1ns/1ps
module jsd_dist_mem
  import jsd_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Write port
  input wire logic we_i,
  input wire logic [SEL_W-1:0] waddr_i,
  input wire logic [31:0] wdata_i,
  // Read ports
  input wire logic [SEL_W-1:0] raddr_a_i,
  output logic [31:0] rdata_a_o,
  input wire logic [SEL_W-1:0] raddr_b_i,
  output logic [31:0] rdata_b_o
);
  logic [31:0] mem [4];
  logic [31:0] next_mem [4];

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_word
      always_comb
      begin
        next_mem[g] = mem[g];
        if (we_i && waddr_i == SEL_W'(g))
        begin
          next_mem[g] = wdata_i;
        end
      end
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          mem[g] <= RST_DIST[g];
        end
        else
        begin
          mem[g] <= next_mem[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_a_o <= '0;
      rdata_b_o <= '0;
    end
    else
    begin
      rdata_a_o <= mem[raddr_a_i];
      rdata_b_o <= mem[raddr_b_i];
    end
  end
endmodule

// ===== verification/jsd_master_model.sv
// Command master model: sends command messages and finishes moves
`timescale 1ns/1ps
module jsd_master_model
  import jsd_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Decoder side
  input wire jsd_move_t move_i,
  output jsd_cmd_t cmd_o,
  output logic motion_done_o
);
  int lag = 1;
  int cnt = 0;
  initial cmd_o = '0;
  initial motion_done_o = 1'b0;
  // One message, changed just after an edge
  task automatic put(input logic srv, input logic dir, input logic [7:0] req,
                     input logic [31:0] arg);
    @(posedge clk_i);
    cmd_o <= '{data: arg, b3: {6'h00, dir, 1'b0}, b2: req, b1: 8'h00,
               b0: {6'h04, srv, 1'b0}};
  endtask
  // Ends a step or station move lag cycles after its start
  always @(posedge clk_i)
  begin
    motion_done_o <= (cnt == 1);
    if (move_i.start && move_i.kind != MK_JOG)
      cnt <= lag;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
endmodule

// ===== verification/tb_top.sv
// Self-checking bench of the move command decoder
`timescale 1ns/1ps
module tb_top;
  import jsd_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [31:0] wdat = '0;
  logic [31:0] rdat;
  logic ack;
  jsd_cmd_t cmd;
  logic done;
  jsd_move_t mv;
  logic busy;
  int err_count = 0;
  int checked = 0;
  localparam logic [31:0] POS = 32'h0001_0000;
  logic [31:0] pos = POS;

  always #10 clk_i = ~clk_i;

  jsd_move_decoder jsd_move_decoder_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .cmd_i(cmd), .present_pos_i(pos), .motion_done_i(done), .move_o(mv), .busy_o(busy));

  jsd_master_model jsd_master_model_i (
    .clk_i(clk_i), .move_i(mv), .cmd_o(cmd), .motion_done_o(done));

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Classic single cycle, held until ack is sampled high at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
      @(posedge clk_i);
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wait_start(output jsd_move_t m);
    int n;
    n = 0;
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while (mv.start !== 1'b1 && n < 20);
    chk("start", 1, mv.start);
    m = mv;
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while (busy !== 1'b0 && n < 60);
    chk("idle", 0, busy);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] q;
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b0, OFS_DIST0 + 8'(4 * i), 32'h0, q);
      chk("dist", RST_DIST[i], q);
    end
    wb(1'b0, OFS_JOG_SPEED, 32'h0, q);
    chk("jog_speed", RST_JOG_SPEED, q);
    wb(1'b0, 8'h40, 32'h0, q);
    chk("unmapped", 32'h0, q);
    $display("test regs done");
  endtask

  task automatic t_jog;
    jsd_move_t m;
    logic [31:0] q;
    wb(1'b1, OFS_CTRL, 32'h0, q);
    jsd_master_model_i.put(1'b0, 1'b1, 8'h08, 32'd50);
    repeat (4) @(negedge clk_i);
    chk("servo_off", 0, busy);
    jsd_master_model_i.put(1'b0, 1'b1, 8'h00, 32'd50);
    jsd_master_model_i.put(1'b1, 1'b1, 8'h08, 32'd50);
    wait_start(m);
    chk("jog_kind", 32'(MK_JOG), 32'(m.kind));
    chk("jog_dir", 1, m.dir);
    chk("ratio", RST_JOG_SPEED * 50 / RATIO_FULL, m.speed);
    jsd_master_model_i.put(1'b1, 1'b1, 8'h08, 32'd300);
    repeat (3) @(negedge clk_i);
    chk("ratio_max", RST_JOG_SPEED * RATIO_MAX / RATIO_FULL, mv.speed);
    jsd_master_model_i.put(1'b1, 1'b1, 8'h08, RATIO_FULL);
    repeat (3) @(negedge clk_i);
    chk("ratio_full", RST_JOG_SPEED, mv.speed);
    jsd_master_model_i.put(1'b1, 1'b1, 8'h00, 32'd0);
    repeat (3) @(negedge clk_i);
    chk("jog_stop", 0, mv.speed);
    wb(1'b1, OFS_CTRL, 32'h1, q);
    jsd_master_model_i.put(1'b1, 1'b0, 8'h08, 32'd300000);
    wait_start(m);
    chk("jog_dir0", 0, m.dir);
    chk("speed_max", SPEED_MAX, m.speed);
    jsd_master_model_i.put(1'b0, 1'b0, 8'h08, 32'd300000);
    wait_idle;
    chk("servo_stop", 0, mv.speed);
    $display("test jog done");
  endtask

  task automatic t_step;
    jsd_move_t m;
    logic [31:0] q;
    logic [31:0] d;
    wb(1'b1, OFS_DIST0 + 8'h08, 32'h0000_1234, q);
    for (int i = 0; i < 4; i++)
    begin
      d = (i == 2) ? 32'h0000_1234 : RST_DIST[i];
      jsd_master_model_i.lag = (i == 1) ? 20 : 1;
      jsd_master_model_i.put(1'b1, i[0], 8'h10, 32'(i));
      pos <= POS + 32'(16 * i);
      wait_start(m);
      chk("step_kind", 32'(MK_STEP), 32'(m.kind));
      chk("step_speed", RST_MOVE_SPEED, m.speed);
      chk("step_target", i[0] ? pos - d : pos + d, m.target);
      jsd_master_model_i.put(1'b1, i[0], 8'h00, 32'(i));
      wait_idle;
    end
    $display("test step done");
  endtask

  task automatic t_station;
    jsd_move_t m;
    logic [31:0] q;
    wb(1'b1, OFS_STATIONS, 32'd4, q);
    wb(1'b1, OFS_PITCH, 32'd90000, q);
    jsd_master_model_i.put(1'b1, 1'b1, 8'h20, 32'd2);
    wait_start(m);
    chk("stn_kind", 32'(MK_STATION), 32'(m.kind));
    chk("stn_target", 32'd180000, m.target);
    chk("stn_dir", 1, m.dir);
    jsd_master_model_i.put(1'b1, 1'b1, 8'h00, 32'd2);
    wait_idle;
    jsd_master_model_i.put(1'b1, 1'b1, 8'h20, 32'd4);
    repeat (4) @(negedge clk_i);
    chk("stn_refused", 0, busy);
    wb(1'b0, OFS_STATUS, 32'h0, q);
    chk("reject", 1, q[5]);
    jsd_master_model_i.put(1'b1, 1'b1, 8'h00, 32'd4);
    $display("test station done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_jog;
    t_step;
    t_station;
    finish_test;
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    finish_test;
  end
endmodule
